// ===== dv/eac_tb.sv
// self-checking bench of the eeprom access controller
`timescale 1ns/10ps
module testbench;
  import eac_pkg::*;
  localparam int WC = 60;
  logic clk, srst, pwr_srst, io_wr_en, io_rd_en, gie, spm_busy, sleep_pd;
  logic [IO_AW-1:0] io_addr;
  logic [7:0] io_wdata, rdata, v, last_low;
  logic rdy_irq, stall, osc_req;
  int fail_count = 0;
  int comparisons = 0;
  int low_cnt = 0;

  eac_controller #(.WRITE_CYCLES(WC)) dut (
    .I_CLK(clk), .I_SRST(srst), .I_PWR_SRST(pwr_srst), .I_IO_ADDR(io_addr),
    .I_IO_WR(io_wr_en), .I_IO_RD(io_rd_en), .I_IO_WDATA(io_wdata),
    .I_GLOBAL_IE(gie), .I_SELF_PROG_BUSY(spm_busy), .I_SLEEP_PD(sleep_pd),
    .O_IO_RDATA(rdata), .O_READY_IRQ(rdy_irq), .O_CPU_STALL(stall),
    .O_OSC_REQ(osc_req)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // length of the last low stretch of the ready request, in cycles
  always @(posedge clk) begin
    low_cnt <= (rdy_irq === 1'b0) ? low_cnt + 1 : 0;
    if (rdy_irq === 1'b1 && low_cnt != 0) last_low <= low_cnt[7:0];
  end

  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    tick(1);
    io_addr = a;
    io_wdata = d;
    io_wr_en = 1'b1;
    tick(1);
    io_wr_en = 1'b0;
  endtask : io_wr

  task automatic io_rd(input logic [5:0] a, output logic [7:0] d);
    tick(1);
    io_addr = a;
    io_rd_en = 1'b1;
    tick(1);
    io_rd_en = 1'b0;
    d = rdata;
  endtask : io_rd

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    io_rd(a, d);
    chk(d, exp);
  endtask : rd_chk

  // counts stalled cycles, starting with the one launched by the access
  task automatic stall_cnt(output logic [7:0] c);
    c = 8'h00;
    repeat (8) begin
      if (stall === 1'b1) c++;
      tick(1);
    end
  endtask : stall_cnt

  task automatic set_addr(input logic [11:0] a);
    io_wr(OFS_ADDRL, a[7:0]);
    io_wr(OFS_ADDRH, {4'h0, a[11:8]});
  endtask : set_addr

  task automatic ee_read(input logic [11:0] a, output logic [7:0] d);
    logic [7:0] c;
    set_addr(a);
    io_wr(OFS_CTRL, 8'h01);
    stall_cnt(c);
    chk(c, 8'h04);
    io_rd(OFS_DATA, d);
  endtask : ee_read

  task automatic wait_idle();
    int i;
    v = 8'h02;
    for (i = 0; i < 400 && v[1] !== 1'b0; i++) io_rd(OFS_CTRL, v);
    if (v[1] !== 1'b0) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_idle

  task automatic wait_irq();
    int i;
    for (i = 0; i < 400 && rdy_irq !== 1'b1; i++) tick(1);
    if (rdy_irq !== 1'b1) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_irq

  initial begin
    {io_wr_en, io_rd_en, gie, spm_busy, sleep_pd} = 5'h00;
    io_addr = 6'h00;
    io_wdata = 8'h00;
    srst = 1'b1;
    pwr_srst = 1'b1;
    tick(20);
    srst = 1'b0;
    pwr_srst = 1'b0;
    gie = 1'b1;
    rd_chk(OFS_CTRL, 8'h00);
    rd_chk(OFS_DATA, DATA_RST);
    chk({7'h00, rdy_irq}, 8'h00);
    io_wr(OFS_ADDRH, 8'hff);
    rd_chk(OFS_ADDRH, 8'h0f);
    // strobe without enable, then enable window and its expiry
    io_wr(OFS_CTRL, 8'h02);
    stall_cnt(v);
    chk(v, 8'h00);
    rd_chk(OFS_CTRL, 8'h00);
    io_wr(OFS_CTRL, 8'h04);
    rd_chk(OFS_CTRL, 8'h04);
    rd_chk(OFS_CTRL, 8'h04);
    rd_chk(OFS_CTRL, 8'h00);
    io_wr(OFS_CTRL, 8'h04);
    tick(3);
    io_wr(OFS_CTRL, 8'h02);
    stall_cnt(v);
    chk(v, 8'h00);
    spm_busy = 1'b1;
    io_wr(OFS_CTRL, 8'h04);
    io_wr(OFS_CTRL, 8'h02);
    stall_cnt(v);
    chk(v, 8'h00);
    spm_busy = 1'b0;
    // strobe on the last cycle of the window, ready request enabled
    set_addr(12'habc);
    io_wr(OFS_DATA, 8'h5a);
    io_wr(OFS_CTRL, 8'h0c);
    tick(2);
    io_wr(OFS_CTRL, 8'h0a);
    stall_cnt(v);
    chk(v, 8'h02);
    chk({7'h00, rdy_irq}, 8'h00);
    rd_chk(OFS_CTRL, 8'h0a);
    io_wr(OFS_ADDRL, 8'h11);
    rd_chk(OFS_ADDRL, 8'hbc);
    io_wr(OFS_CTRL, 8'h09);
    stall_cnt(v);
    chk(v, 8'h00);
    wait_irq();
    tick(1);
    chk(last_low, 8'(WC));
    tick(5);
    chk({7'h00, rdy_irq}, 8'h01);
    gie = 1'b0;
    tick(2);
    chk({7'h00, rdy_irq}, 8'h00);
    gie = 1'b1;
    io_wr(OFS_CTRL, 8'h00);
    tick(2);
    chk({7'h00, rdy_irq}, 8'h00);
    // read back: four stall cycles, strobe clears itself
    io_wr(OFS_CTRL, 8'h01);
    stall_cnt(v);
    chk(v, 8'h04);
    rd_chk(OFS_CTRL, 8'h00);
    rd_chk(OFS_DATA, 8'h5a);
    // a write that runs through power-down and a cpu reset
    sleep_pd = 1'b1;
    set_addr(12'h123);
    io_wr(OFS_DATA, 8'hc3);
    io_wr(OFS_CTRL, 8'h04);
    io_wr(OFS_CTRL, 8'h02);
    tick(3);
    chk({7'h00, osc_req}, 8'h01);
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    wait_idle();
    chk({7'h00, osc_req}, 8'h01);
    sleep_pd = 1'b0;
    tick(2);
    chk({7'h00, osc_req}, 8'h00);
    ee_read(12'h123, v);
    chk(v, 8'hc3);
    ee_read(12'habc, v);
    chk(v, 8'h5a);
    stop_test();
  end
endmodule : testbench

// ===== src/eac_controller.sv
// eeprom access controller: i/o registers, strobes, stall, array
//
// Contract
// (RULE_01) ready request only with ready_irq_enable and global enable set
// (RULE_02) ready request is a level held while write_strobe reads zero
// (RULE_03) write strobe starts programming only within four cycles of enable
// (RULE_04) write strobe without master_write_enable does nothing
// (RULE_05) master_write_enable clears itself four cycles after being set
// (RULE_06) software polls, loads address and data, sets enable, then strobe
// (RULE_07) software finishes flash self-programming before an eeprom write
// (RULE_08) software should mask interrupts during the last four write steps
// (RULE_09) write_strobe reads one during programming, clears when done
// (RULE_10) an accepted write stalls the cpu two cycles
// (RULE_11) read strobe loads data register in the same instruction
// (RULE_12) every read stalls the cpu four cycles
// (RULE_13) during a write, reads are ignored and address is frozen
// (RULE_14) write lasts 8448 ticks of the 1 MHz oscillator
// (RULE_15) write finishes through power-down; oscillator then keeps running
// (RULE_16) cpu reset does not abort a write in progress
// (RULE_17) address is 12 bits, upper four bits read zero
// (RULE_18) data register feeds writes and captures reads
// (RULE_19) read strobe clears itself after the read
`timescale 1ns/10ps
module eac_controller
  import eac_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CLK_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_PWR_SRST,
  input wire logic [IO_AW-1:0] I_IO_ADDR,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire logic [7:0] I_IO_WDATA,
  input wire logic I_GLOBAL_IE,
  input wire logic I_SELF_PROG_BUSY,
  input wire logic I_SLEEP_PD,
  output logic [7:0] O_IO_RDATA,
  output logic O_READY_IRQ,
  output logic O_CPU_STALL,
  output logic O_OSC_REQ
);
  eac_timer_if tif ();

  logic [7:0] mem [EE_DEPTH];
  logic [7:0] rd_peek;
  logic [EE_AW-1:0] addr_reg;
  logic [7:0] data_reg;
  logic rie_reg;
  logic mwe_reg;
  logic [2:0] mwe_cnt_reg;
  logic rs_reg;
  logic [2:0] stall_cnt_reg;
  logic [2:0] stall_cnt_next;
  logic stall_reg;
  logic irq_reg;
  logic osc_req_reg;
  logic [7:0] rdata_reg;
  logic wr_ctrl;
  logic wr_data;
  logic wr_addrl;
  logic wr_addrh;
  logic wr_accept;
  logic rd_accept;

  assign wr_ctrl = I_IO_WR && (I_IO_ADDR == OFS_CTRL);
  assign wr_data = I_IO_WR && (I_IO_ADDR == OFS_DATA);
  assign wr_addrl = I_IO_WR && (I_IO_ADDR == OFS_ADDRL);
  assign wr_addrh = I_IO_WR && (I_IO_ADDR == OFS_ADDRH);

  // the enable must already stand; one write setting both bits is refused
  assign wr_accept = wr_ctrl && I_IO_WDATA[BIT_WS] && mwe_reg // RULE_03
                     && !tif.busy && !I_SELF_PROG_BUSY; // RULE_04
  // a write strobe in the same byte takes priority over the read
  assign rd_accept = wr_ctrl && I_IO_WDATA[BIT_RS] && !tif.busy // RULE_13
                     && !wr_accept;

  // a read on the edge that programs the array must see the new byte
  assign rd_peek = (tif.done && tif.pgm_addr == addr_reg) ? tif.pgm_data
                   : mem[addr_reg];

  assign tif.start = wr_accept;
  assign tif.addr = addr_reg;
  assign tif.data = data_reg;

  eac_write_timer #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk(I_CLK),
    .pwr_srst(I_PWR_SRST),
    .tif(tif)
  );

  // array content is nonvolatile, so it has no reset
  always_ff @(posedge I_CLK) begin
    if (tif.done) begin
      mem[tif.pgm_addr] <= tif.pgm_data;
    end
  end

  // address follows the power reset so a write in flight keeps its target
  always_ff @(posedge I_CLK) begin
    if (I_PWR_SRST) begin
      addr_reg <= ADDR_RST;
    end else if (!tif.busy) begin // RULE_13
      if (wr_addrl) begin
        addr_reg[7:0] <= I_IO_WDATA;
      end
      if (wr_addrh) begin
        addr_reg[EE_AW-1:8] <= I_IO_WDATA[EE_AW-9:0]; // RULE_17
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      data_reg <= DATA_RST;
    end else if (rd_accept) begin
      data_reg <= rd_peek; // RULE_11 RULE_18
    end else if (wr_data) begin
      data_reg <= I_IO_WDATA; // RULE_18
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rie_reg <= 1'b0;
    end else if (wr_ctrl) begin
      rie_reg <= I_IO_WDATA[BIT_RIE];
    end
  end

  // a rewrite inside the window does not extend it
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      mwe_reg <= 1'b0;
      mwe_cnt_reg <= 3'h0;
    end else if (wr_ctrl && I_IO_WDATA[BIT_MWE] && !mwe_reg) begin
      mwe_reg <= 1'b1;
      mwe_cnt_reg <= MWE_WINDOW; // RULE_05
    end else if (mwe_reg) begin
      if (mwe_cnt_reg == 3'h1) begin
        mwe_reg <= 1'b0; // RULE_05
        mwe_cnt_reg <= 3'h0;
      end else begin
        mwe_cnt_reg <= mwe_cnt_reg - 3'h1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rs_reg <= 1'b0;
    end else begin
      rs_reg <= rd_accept; // RULE_19
    end
  end

  always_comb begin
    if (wr_accept) begin
      stall_cnt_next = STALL_WR; // RULE_10
    end else if (rd_accept) begin
      stall_cnt_next = STALL_RD; // RULE_12
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_next = stall_cnt_reg - 3'h1;
    end else begin
      stall_cnt_next = 3'h0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      stall_cnt_reg <= 3'h0;
      stall_reg <= 1'b0;
    end else begin
      stall_cnt_reg <= stall_cnt_next;
      stall_reg <= (stall_cnt_next != 3'h0); // RULE_10 RULE_12
    end
  end

  // level request: software masks it rather than acknowledging it
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= rie_reg && I_GLOBAL_IE && !tif.busy; // RULE_01 RULE_02
    end
  end

  // once set by a running write, the request stays until both the write and sleep have ended
  always_ff @(posedge I_CLK) begin
    if (I_PWR_SRST) begin
      osc_req_reg <= 1'b0;
    end else begin
      osc_req_reg <= tif.busy || (osc_req_reg && I_SLEEP_PD); // RULE_15
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rdata_reg <= 8'h00;
    end else if (I_IO_RD) begin
      case (I_IO_ADDR)
        OFS_CTRL: rdata_reg <= {4'h0, rie_reg, mwe_reg, tif.busy, rs_reg};
        OFS_DATA: rdata_reg <= data_reg;
        OFS_ADDRL: rdata_reg <= addr_reg[7:0];
        OFS_ADDRH: rdata_reg <= {4'h0, addr_reg[EE_AW-1:8]}; // RULE_17
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign O_IO_RDATA = rdata_reg;
  assign O_READY_IRQ = irq_reg;
  assign O_CPU_STALL = stall_reg;
  assign O_OSC_REQ = osc_req_reg;

  sequence s_mwe_set;
    wr_ctrl && I_IO_WDATA[BIT_MWE] && !mwe_reg;
  endsequence

  sequence s_stall_two;
    stall_reg [*2] ##1 !stall_reg;
  endsequence

  sequence s_stall_four;
    stall_reg [*4] ##1 !stall_reg;
  endsequence

  a_irq_gated: assert property (@(posedge I_CLK) // RULE_01
    disable iff (I_SRST)
    O_READY_IRQ |-> ($past(rie_reg) && $past(I_GLOBAL_IE)))
    else $error("ready request without both enables");

  a_irq_level: assert property (@(posedge I_CLK) // RULE_02
    disable iff (I_SRST || I_PWR_SRST)
    (rie_reg && I_GLOBAL_IE && !tif.busy) [*2] |-> O_READY_IRQ ##1 O_READY_IRQ)
    else $error("ready request not held as a level");

  a_mwe_window: assert property (@(posedge I_CLK) // RULE_05
    disable iff (I_SRST)
    s_mwe_set |=> mwe_reg [*4] ##1 !mwe_reg)
    else $error("master write enable window not four cycles");

  a_write_start: assert property (@(posedge I_CLK) // RULE_03
    disable iff (I_SRST || I_PWR_SRST)
    (wr_ctrl && I_IO_WDATA[BIT_WS] && mwe_reg && !tif.busy
     && !I_SELF_PROG_BUSY) |=> tif.busy)
    else $error("strobe inside window did not start a write");

  a_no_mwe_no_write: assert property (@(posedge I_CLK) // RULE_04
    disable iff (I_SRST || I_PWR_SRST)
    (wr_ctrl && I_IO_WDATA[BIT_WS] && !mwe_reg && !tif.busy) |=> !tif.busy)
    else $error("write started without master write enable");

  a_write_stall: assert property (@(posedge I_CLK) // RULE_10
    disable iff (I_SRST || I_PWR_SRST)
    wr_accept |=> s_stall_two)
    else $error("write stall not two cycles");

  a_read_stall: assert property (@(posedge I_CLK) // RULE_12
    disable iff (I_SRST || I_PWR_SRST)
    rd_accept |=> s_stall_four)
    else $error("read stall not four cycles");

  a_read_data: assert property (@(posedge I_CLK) // RULE_11
    disable iff (I_SRST || I_PWR_SRST)
    rd_accept |=> (data_reg == $past(rd_peek) && rs_reg))
    else $error("read did not load the data register");

  a_addr_frozen: assert property (@(posedge I_CLK) // RULE_13
    disable iff (I_PWR_SRST)
    tif.busy |=> $stable(addr_reg))
    else $error("address changed during a write");

  a_read_ignored: assert property (@(posedge I_CLK) // RULE_13
    disable iff (I_SRST || I_PWR_SRST)
    (wr_ctrl && I_IO_WDATA[BIT_RS] && tif.busy) |=> !rs_reg)
    else $error("read accepted during a write");

  a_rs_self_clear: assert property (@(posedge I_CLK) // RULE_19
    disable iff (I_SRST)
    (rs_reg && !rd_accept) |=> !rs_reg)
    else $error("read strobe did not clear");

  a_osc_held: assert property (@(posedge I_CLK) // RULE_15
    disable iff (I_PWR_SRST)
    (tif.done && I_SLEEP_PD) ##1 I_SLEEP_PD |=> O_OSC_REQ)
    else $error("oscillator request dropped in power-down after write");

  a_ws_done: assert property (@(posedge I_CLK) // RULE_09
    disable iff (I_PWR_SRST)
    tif.done |-> (!tif.busy
      ##1 mem[$past(tif.pgm_addr)] == $past(tif.pgm_data)))
    else $error("write completion did not program the array");

  a_irq_off: assert property (@(posedge I_CLK) // RULE_01
    disable iff (I_SRST)
    (!rie_reg || !I_GLOBAL_IE) |=> !O_READY_IRQ)
    else $error("ready request while an enable is clear");

  a_osc_busy: assert property (@(posedge I_CLK) // RULE_15
    disable iff (I_PWR_SRST)
    tif.busy |=> O_OSC_REQ)
    else $error("oscillator request missing during a write");

  a_stall_idle: assert property (@(posedge I_CLK) // RULE_10 RULE_12
    disable iff (I_SRST)
    (!wr_accept && !rd_accept && stall_cnt_reg == 3'h0) |=> !O_CPU_STALL)
    else $error("cpu stalled without an access");
endmodule : eac_controller

// ===== src/eac_pkg.sv
// shared constants and types of the eeprom access controller
package eac_pkg;
  // i/o space offsets of the access registers
  localparam int IO_AW = 6;
  localparam logic [5:0] OFS_CTRL = 6'h1c;
  localparam logic [5:0] OFS_DATA = 6'h1d;
  localparam logic [5:0] OFS_ADDRL = 6'h1e;
  localparam logic [5:0] OFS_ADDRH = 6'h1f;

  // eeprom_control field positions
  localparam int BIT_RIE = 3;
  localparam int BIT_MWE = 2;
  localparam int BIT_WS = 1;
  localparam int BIT_RS = 0;

  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [11:0] ADDR_RST = 12'h000;

  // array geometry
  localparam int EE_AW = 12;
  localparam int EE_DEPTH = 4096;

  // cycle counts on the cpu clock
  localparam logic [2:0] MWE_WINDOW = 3'h4;
  localparam logic [2:0] STALL_WR = 3'h2;
  localparam logic [2:0] STALL_RD = 3'h4;

  // write timing: calibrated oscillator cycles scaled to cpu clocks
  localparam int CLK_PERIOD_NS = 100;
  localparam int OSC_PERIOD_NS = 1000;
  localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WRITE_OSC_CYCLES = 8448;
  localparam int WRITE_CLK_CYCLES = WRITE_OSC_CYCLES * OSC_DIV;
  localparam int WT_W = 17;

  typedef enum logic {EAC_T_IDLE, EAC_T_PROG} eac_tstate_e;
endpackage : eac_pkg

// ===== src/eac_timer_if.sv
// link between the register side and the write engine
`timescale 1ns/10ps
interface eac_timer_if;
  import eac_pkg::*;
  logic start;
  logic [EE_AW-1:0] addr;
  logic [7:0] data;
  logic busy;
  logic done;
  logic [EE_AW-1:0] pgm_addr;
  logic [7:0] pgm_data;
  modport ctrl (output start, addr, data,
                input busy, done, pgm_addr, pgm_data);
  modport engine (input start, addr, data,
                  output busy, done, pgm_addr, pgm_data);
endinterface : eac_timer_if

// ===== src/eac_write_timer.sv
// self-timed write engine, survives the cpu-side reset
`timescale 1ns/10ps
module eac_write_timer
  import eac_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CLK_CYCLES
) (
  input wire logic clk,
  input wire logic pwr_srst,
  eac_timer_if.engine tif
);
  eac_tstate_e state_reg;
  logic [WT_W-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;
  logic [EE_AW-1:0] pgm_addr_reg;
  logic [7:0] pgm_data_reg;

  assign tif.busy = busy_reg;
  assign tif.done = done_reg;
  assign tif.pgm_addr = pgm_addr_reg;
  assign tif.pgm_data = pgm_data_reg;

  // only the power reset stops a write; cpu reset never reaches here
  always_ff @(posedge clk) begin
    if (pwr_srst) begin
      state_reg <= EAC_T_IDLE;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        EAC_T_IDLE: begin
          if (tif.start) begin
            state_reg <= EAC_T_PROG;
            cnt_reg <= WT_W'(WRITE_CYCLES); // RULE_14
            busy_reg <= 1'b1; // RULE_09
          end
        end
        EAC_T_PROG: begin
          if (cnt_reg == WT_W'(1)) begin
            state_reg <= EAC_T_IDLE;
            busy_reg <= 1'b0; // RULE_09
            done_reg <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - WT_W'(1); // RULE_16
          end
        end
        default: state_reg <= EAC_T_IDLE;
      endcase
    end
  end

  // target latched at start so later data writes cannot disturb it
  always_ff @(posedge clk) begin
    if (pwr_srst) begin
      pgm_addr_reg <= ADDR_RST;
      pgm_data_reg <= DATA_RST;
    end else if (tif.start && state_reg == EAC_T_IDLE) begin
      pgm_addr_reg <= tif.addr;
      pgm_data_reg <= tif.data;
    end
  end

  a_write_load: assert property (@(posedge clk) // RULE_14
    disable iff (pwr_srst)
    (tif.start && !busy_reg) |=> (busy_reg && cnt_reg == WT_W'(WRITE_CYCLES)))
    else $error("write timer not loaded with full write time");

  a_busy_holds: assert property (@(posedge clk) // RULE_16
    disable iff (pwr_srst)
    (busy_reg && cnt_reg != WT_W'(1)) |=> busy_reg)
    else $error("write ended before its time elapsed");
endmodule : eac_write_timer
